// ---- hrc_pkg.sv ----
// Purpose: Shared constants for the hardware reset control block
// Assumes: One 100 MHz clock
// Notes: Vector fetch length and pin count are plain defaults
package hrc_pkg;
  localparam int PORT_PINS = 16;
  localparam int ADDR_W = 20;
  localparam logic [19:0] RESET_VECTOR_ADDR = 20'hffffc;
  localparam logic [1:0] SYNC_ONES = 2'h3;
  localparam logic [3:0] VEC_BYTES = 4'h3;
  localparam logic [3:0] VEC_LAST = 4'h2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [19:0] ADDR_ZERO = 20'h00000;
  typedef enum logic [2:0] {ST_HOLD, ST_RELEASE, ST_FETCH, ST_RUN} hrc_state_t;
endpackage

// ---- hrc_pin_sync.sv ----
// Purpose: Three-stage synchroniser for an outside level
// Assumes: Input from outside the sys_clk domain
// Notes: A change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module hrc_pin_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pinIn,
  output logic levelOut
);
  logic s1Reg;
  logic s2Reg;
  logic s3Reg;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1Reg <= 1'b0;
      s2Reg <= 1'b0;
      s3Reg <= 1'b0;
    end else begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      levelOut <= 1'b0;
    end else if (s2Reg == s3Reg) begin
      levelOut <= s3Reg;
    end
  end
endmodule
`default_nettype wire

// ---- hrc_reset_ctrl.sv ----
// Purpose: Hardware reset control for a 16-bit microcomputer
// Assumes: sys_clk is the main clock; resetPinN comes from the board
// Notes: CPU and register reset are released on the filtered rising edge
// ****************
// ****************
`timescale 1ns/10ps
`default_nettype none
module hrc_reset_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic resetPinN,
  input wire logic swResetReq,
  input wire logic wdtUnderflowReset,
  input wire logic oscStopReset,
  input wire logic ramWriteActive,
  input wire logic [7:0] vecData,
  input wire logic vecValid,
  output logic pinResetN,
  output logic portInputForceN,
  output logic oscResetN,
  output logic cpuRegResetN,
  output logic ramWriteBlockN,
  output logic ramUndefined,
  output logic vecReadReq,
  output logic [hrc_pkg::ADDR_W-1:0] vecAddr,
  output logic [hrc_pkg::ADDR_W-1:0] startAddr,
  output logic cpuRun
);
  import hrc_pkg::*;

  // ****************
  // Pin filtering
  // ****************
  logic pinHigh;
  logic pinHighDly_reg;
  hrc_pin_sync uSync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pinIn(resetPinN),
    .levelOut(pinHigh)
  );
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pinHighDly_reg <= 1'b0;
    end else begin
      pinHighDly_reg <= pinHigh;
    end
  end

  // Raw pin level acts at once; waiting on the filter would delay pin safety
  logic internalReset;
  assign internalReset = swResetReq | wdtUnderflowReset | oscStopReset;
  assign pinResetN = resetPinN;
  assign portInputForceN = resetPinN;
  assign oscResetN = resetPinN;
  assign ramWriteBlockN = 1'b1;

  // ****************
  // Sequencer
  // ****************
  hrc_state_t state_reg;
  hrc_state_t state_next;
  logic [3:0] cnt_reg;
  logic [19:0] addr_reg;
  logic pinRise;
  assign pinRise = pinHigh & ~pinHighDly_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HOLD: begin
        if (pinRise) begin
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: state_next = ST_FETCH;
      ST_FETCH: begin
        if (vecValid && cnt_reg == VEC_LAST) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_HOLD;
    endcase
    if (!pinHigh || internalReset) begin
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Internal sources also wait for a new filtered pin rise before release, keeping one path
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpuRegResetN <= 1'b0;
    end else begin
      cpuRegResetN <= (state_next != ST_HOLD);
    end
  end

  // ****************
  // Vector fetch
  // ****************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= CNT_ZERO;
      addr_reg <= ADDR_ZERO;
    end else if (state_reg != ST_FETCH) begin
      cnt_reg <= CNT_ZERO;
      if (state_reg == ST_RELEASE) begin
        addr_reg <= ADDR_ZERO;
      end
    end else if (vecValid) begin
      // Each byte lands in its own lane; top byte gives only a nibble
      if (cnt_reg == CNT_ZERO) begin
        addr_reg <= {addr_reg[19:8], vecData};
      end else if (cnt_reg == CNT_ONE) begin
        addr_reg <= {addr_reg[19:16], vecData, addr_reg[7:0]};
      end else begin
        addr_reg <= {vecData[3:0], addr_reg[15:0]};
      end
      cnt_reg <= cnt_reg + CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      startAddr <= ADDR_ZERO;
      cpuRun <= 1'b0;
    end else begin
      cpuRun <= (state_next == ST_RUN);
      if (state_reg == ST_FETCH && state_next == ST_RUN) begin
        startAddr <= {vecData[3:0], addr_reg[15:0]};
      end
    end
  end

  assign vecReadReq = (state_reg == ST_FETCH);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vecAddr <= RESET_VECTOR_ADDR;
    end else begin
      vecAddr <= RESET_VECTOR_ADDR + {16'h0000, state_next == ST_FETCH && vecValid && state_reg == ST_FETCH
        ? cnt_reg + CNT_ONE : (state_reg == ST_FETCH ? cnt_reg : CNT_ZERO)};
    end
  end

  // ****************
  // RAM integrity
  // ****************
  // Flag is sticky: only a clean write-free pin reset could vouch for RAM
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ramUndefined <= 1'b0;
    end else if (!resetPinN && ramWriteActive) begin
      ramUndefined <= 1'b1;
    end
  end

  // ****************
  // Checks
  // ****************
  sequence pinRiseSeen;
    pinHigh && !pinHighDly_reg && !internalReset;
  endsequence
  sequence releaseSeen;
    cpuRegResetN && state_reg == ST_RELEASE;
  endsequence
  // Last vector byte accepted with nothing pulling back into reset
  sequence fetchDone;
    vecReadReq && vecValid && cnt_reg == VEC_LAST && pinHigh && !internalReset;
  endsequence

  pin_safe_a: assert property (@(posedge sys_clk) disable iff (reset)
    !resetPinN |-> !pinResetN && !portInputForceN && !oscResetN) else $error("pins not reset");
  release_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
    pinRiseSeen ##1 1'b1 |-> releaseSeen) else $error("no release on rise");
  held_low_a: assert property (@(posedge sys_clk) disable iff (reset)
    !pinHigh |=> !cpuRegResetN) else $error("cpu out of reset while pin low");
  sw_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    internalReset |=> !cpuRegResetN && !cpuRun) else $error("source ignored");
  fetch_start_a: assert property (@(posedge sys_clk) disable iff (reset)
    (releaseSeen and (pinHigh && !internalReset)) |=> vecReadReq) else $error("no vector fetch");
  run_addr_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(cpuRun) |-> startAddr == {$past(vecData[3:0]), $past(addr_reg[15:0])}) else $error("bad start");
  ram_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
    ramWriteBlockN) else $error("ram touched");
  ram_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    !resetPinN && ramWriteActive |=> ramUndefined [*2]) else $error("ram flag lost");
  sync_lag_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(resetPinN) |-> !cpuRegResetN [*3]) else $error("release before sync");
  osc_port_a: assert property (@(posedge sys_clk) disable iff (reset)
    oscResetN == portInputForceN) else $error("osc and port mismatch");
  fetch_done_a: assert property (@(posedge sys_clk) disable iff (reset)
    fetchDone |=> cpuRun) else $error("no run after fetch");
  fetch_base_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(vecReadReq) |-> vecAddr == RESET_VECTOR_ADDR) else $error("fetch not at vector");
  addr_step_a: assert property (@(posedge sys_clk) disable iff (reset)
    vecReadReq && vecValid && cnt_reg == CNT_ZERO && pinHigh && !internalReset
    |=> vecAddr == RESET_VECTOR_ADDR + {16'h0000, CNT_ONE}) else $error("vector address not stepped");
  run_release_a: assert property (@(posedge sys_clk) disable iff (reset)
    cpuRun |-> cpuRegResetN) else $error("run while in reset");
  held_run_a: assert property (@(posedge sys_clk) disable iff (reset)
    !pinHigh |=> !cpuRun) else $error("run while pin low");
  ram_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
    ramUndefined |=> ramUndefined) else $error("ram flag cleared");
endmodule
`default_nettype wire

// ---- hrc_reset_circuit.sv ----
// Purpose: Model of the board circuit that drives the reset pin
// Assumes: Bench calls pullLow and letGo from its falling-edge process
// Notes: letGo stalls until the low time is long enough
`timescale 1ns/10ps
`default_nettype none
module hrc_reset_circuit (
  input wire logic sys_clk,
  output logic resetPinN
);
  int lowCycles = 0;
  initial resetPinN = 1'b0;
  always @(posedge sys_clk) begin
    lowCycles <= resetPinN ? 0 : lowCycles + 1;
  end
  task automatic pullLow();
    resetPinN = 1'b0;
  endtask
  // Stretched to 20 clocks even if the bench asks earlier
  task automatic letGo();
    while (lowCycles < 20) @(negedge sys_clk);
    resetPinN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the reset controller
// Assumes: Inputs change on the falling edge
// Notes: Vector bytes come from a fixed-seed shift register
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hrc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic swResetReq = 1'b0, wdtUnderflowReset = 1'b0, oscStopReset = 1'b0;
  logic ramWriteActive = 1'b0, vecValid = 1'b0;
  logic [7:0] vecData = 8'h00;
  logic [31:0] seed = 32'h76270bfa;
  wire logic resetPinN;
  logic pinResetN, portInputForceN, oscResetN, cpuRegResetN, ramWriteBlockN, ramUndefined, vecReadReq, cpuRun;
  logic [19:0] vecAddr, startAddr;
  int fail_count = 0, samples_checked = 0;
  int bq[$];
  always #5 sys_clk = ~sys_clk;
  hrc_reset_circuit u_circ (.sys_clk(sys_clk), .resetPinN(resetPinN));
  hrc_reset_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .resetPinN(resetPinN), .swResetReq(swResetReq),
    .wdtUnderflowReset(wdtUnderflowReset), .oscStopReset(oscStopReset), .ramWriteActive(ramWriteActive),
    .vecData(vecData), .vecValid(vecValid), .pinResetN(pinResetN), .portInputForceN(portInputForceN),
    .oscResetN(oscResetN), .cpuRegResetN(cpuRegResetN), .ramWriteBlockN(ramWriteBlockN),
    .ramUndefined(ramUndefined), .vecReadReq(vecReadReq), .vecAddr(vecAddr), .startAddr(startAddr),
    .cpuRun(cpuRun));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string what, input logic [19:0] e, input logic [19:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic checkPins(input logic lvl);
    check("pinLevels", {17'h0, {3{lvl}}}, {17'h0, pinResetN, portInputForceN, oscResetN});
  endtask
  task automatic boot();
    int n;
    int e;
    n = 0;
    while (vecReadReq !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    check("cpuRegResetN", 1, cpuRegResetN);
    check("vecReadReq", 1, vecReadReq);
    check("vecAddr", RESET_VECTOR_ADDR, vecAddr);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      bq.push_back(int'(seed[7:0]));
      vecData = seed[7:0];
      vecValid = 1'b1;
      @(negedge sys_clk);
      if (i < 2) check("vecAddr", RESET_VECTOR_ADDR + 20'(i + 1), vecAddr);
    end
    vecValid = 1'b0;
    e = bq[0] + (bq[1] << 8) + ((bq[2] & 15) << 16);
    bq.delete();
    repeat (2) @(negedge sys_clk);
    check("startAddr", e[19:0], startAddr);
    check("cpuRun", 1, cpuRun);
    check("vecReadReq", 0, vecReadReq);
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Run is under two hundred clocks; this leaves ample margin
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    checkPins(1'b0);
    check("cpuRegResetN", 0, cpuRegResetN);
    u_circ.letGo();
    #1 checkPins(1'b1);
    check("cpuRegResetN", 0, cpuRegResetN);
    boot();
    for (int s = 0; s < 3; s++) begin
      {oscStopReset, wdtUnderflowReset, swResetReq} = 3'h1 << s;
      repeat (3) @(negedge sys_clk);
      check("cpuRegResetN", 0, cpuRegResetN);
      check("cpuRun", 0, cpuRun);
      u_circ.pullLow();
      {oscStopReset, wdtUnderflowReset, swResetReq} = 3'h0;
      u_circ.letGo();
      boot();
    end
    check("ramUndefined", 0, ramUndefined);
    ramWriteActive = 1'b1;
    u_circ.pullLow();
    #1 checkPins(1'b0);
    repeat (6) @(negedge sys_clk);
    ramWriteActive = 1'b0;
    check("cpuRegResetN", 0, cpuRegResetN);
    check("ramWriteBlockN", 1, ramWriteBlockN);
    u_circ.letGo();
    boot();
    check("ramUndefined", 1, ramUndefined);
    print_verdict();
  end
endmodule
`default_nettype wire
